/* File: cidr_pkg.sv */
package cidr_pkg;

	// Register map
	localparam logic [7:0]  CIDR_PRODUCT_IDENTIFICATION_OFF = 8'h00;
	localparam logic [31:0] CIDR_UNMAPPED_READ              = 32'h0000_0000;

	// Field positions
	localparam int CIDR_PROD_HI_LSB  = 26;
	localparam int CIDR_REV_HI_LSB   = 24;
	localparam int CIDR_STRAP_LSB    = 16;
	localparam int CIDR_BUFSZ_LSB    = 8;
	localparam int CIDR_PROD_LO_LSB  = 2;
	localparam int CIDR_REV_LO_LSB   = 0;
	localparam int CIDR_STRAP_TIED   = 3;

	// Field widths
	localparam int CIDR_PROD_W  = 6;
	localparam int CIDR_REV_W   = 2;
	localparam int CIDR_STRAP_W = 7;
	localparam int CIDR_BUFSZ_W = 8;

	// Identity values (arbitrary, neutral)
	localparam logic [5:0] CIDR_PRODUCT_CODE  = 6'h15;
	localparam logic [1:0] CIDR_REVISION_CODE = 2'h1;

	// Buffer size: bytes divided by the 4 KB unit
	localparam int         CIDR_BUF_BYTES = 163840;
	localparam int         CIDR_BUF_UNIT  = 4096;
	localparam logic [7:0] CIDR_BUF_UNITS = 8'(CIDR_BUF_BYTES / CIDR_BUF_UNIT);

	// Reset values
	localparam logic [6:0]  CIDR_STRAP_RST = 7'h00;
	localparam logic [31:0] CIDR_RDATA_RST = 32'h0000_0000;

endpackage : cidr_pkg

/* File: cidr_strap_latch.sv */
// Holds strap levels captured on the cycle reset is released
module cidr_strap_latch
	import cidr_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic [6:0]  strap_in,
	output logic      [6:0]  strap_q
);

	logic       in_rst_r;
	logic [6:0] strap_r;

	// Remember reset so the first cycle after release is known
	always_ff @(posedge core_clk) begin
		in_rst_r <= srst;
	end

	// Capture once at release, then hold until next reset
	always_ff @(posedge core_clk) begin
		if (srst) begin
			strap_r <= CIDR_STRAP_RST; // see RL1
		end else if (in_rst_r) begin
			strap_r <= strap_in; // see RL4
		end
	end

	// Tied-high strap always reads as one
	always_comb begin
		strap_q                  = strap_r;
		strap_q[CIDR_STRAP_TIED] = 1'b1; // see RL3
	end

endmodule // cidr_strap_latch

/* File: cidr_top.sv */
// Contract
// RL1: All register state comes up cleared after reset unless a field defines its own value.
// RL2: A two-bit revision code reads in bits 25-24 and again in bits 1-0, ignoring writes.
// RL3: Bits 22-16 return the seven strap levels, with bit 19 always reading one.
// RL4: Strap levels are captured as reset is released and held until the next reset.
// RL5: A six-bit product code reads in bits 31-26 and 7-2, with buffer size in 4 KB units in 15-8.
//
// The address-and-strobe port and the register offsets were left to the implementer.
module cidr_top
	import cidr_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic [6:0]  config_strap_pins,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic      [31:0] rdata
);

	// Register word width on the bus
	localparam int WORD_W = 32;

	// Top bit of each field, from its base and width
	localparam int PROD_HI_MSB = CIDR_PROD_HI_LSB + CIDR_PROD_W - 1;
	localparam int REV_HI_MSB  = CIDR_REV_HI_LSB + CIDR_REV_W - 1;
	localparam int STRAP_MSB   = CIDR_STRAP_LSB + CIDR_STRAP_W - 1;
	localparam int BUFSZ_MSB   = CIDR_BUFSZ_LSB + CIDR_BUFSZ_W - 1;
	localparam int PROD_LO_MSB = CIDR_PROD_LO_LSB + CIDR_PROD_W - 1;
	localparam int REV_LO_MSB  = CIDR_REV_LO_LSB + CIDR_REV_W - 1;

	// Reserved gap just above the strap field
	localparam int RSVD_BIT    = STRAP_MSB + 1;

	// Read kind; the unused code falls to the lanes' default and reads zero
	typedef enum logic [1:0] {
		RD_NONE = 2'h0,
		RD_ID   = 2'h1,
		RD_MISS = 2'h3
	} cidr_rd_kind_e;

	// Strap levels held since the last reset release
	logic [CIDR_STRAP_W-1:0] strap_q;

	// Identification word, built one bit at a time
	wire  [WORD_W-1:0]       id_word;

	// Bus decode
	logic                    id_hit;
	cidr_rd_kind_e           rd_kind;

	// Readback lanes, one per field
	logic [CIDR_PROD_W-1:0]  prod_hi_nxt;
	logic [CIDR_PROD_W-1:0]  prod_hi_r;
	logic [CIDR_REV_W-1:0]   rev_hi_nxt;
	logic [CIDR_REV_W-1:0]   rev_hi_r;
	logic                    rsvd_nxt;
	logic                    rsvd_r;
	logic [CIDR_STRAP_W-1:0] strap_rd_nxt;
	logic [CIDR_STRAP_W-1:0] strap_rd_r;
	logic [CIDR_BUFSZ_W-1:0] bufsz_nxt;
	logic [CIDR_BUFSZ_W-1:0] bufsz_r;
	logic [CIDR_PROD_W-1:0]  prod_lo_nxt;
	logic [CIDR_PROD_W-1:0]  prod_lo_r;
	logic [CIDR_REV_W-1:0]   rev_lo_nxt;
	logic [CIDR_REV_W-1:0]   rev_lo_r;

	// Write side has no target
	logic                    unused_w;

	// Strap capture lives in its own small module
	cidr_strap_latch u_strap (
		.core_clk (core_clk),
		.srst     (srst),
		.strap_in (config_strap_pins),
		.strap_q  (strap_q)
	);

	// Single mapped offset; any other address is a miss
	assign id_hit = (addr == CIDR_PRODUCT_IDENTIFICATION_OFF);

	// Classify this cycle's read; idle and hit differ in one bit
	always_comb begin
		rd_kind = RD_NONE;
		if (rd_stb && id_hit) begin
			rd_kind = RD_ID;
		end else if (rd_stb) begin
			rd_kind = RD_MISS;
		end
	end

	// Per-bit source map; a bit outside every field reads zero
	for (genvar b = 0; b < WORD_W; b++) begin : g_id_bit
		if (b >= CIDR_PROD_HI_LSB && b <= PROD_HI_MSB) begin : g_prod_hi
			assign id_word[b] = CIDR_PRODUCT_CODE[b - CIDR_PROD_HI_LSB]; // see RL5
		end else if (b >= CIDR_REV_HI_LSB && b <= REV_HI_MSB) begin : g_rev_hi
			assign id_word[b] = CIDR_REVISION_CODE[b - CIDR_REV_HI_LSB]; // see RL2
		end else if (b >= CIDR_STRAP_LSB && b <= STRAP_MSB) begin : g_strap
			assign id_word[b] = strap_q[b - CIDR_STRAP_LSB]; // see RL3
		end else if (b >= CIDR_BUFSZ_LSB && b <= BUFSZ_MSB) begin : g_bufsz
			assign id_word[b] = CIDR_BUF_UNITS[b - CIDR_BUFSZ_LSB]; // see RL5
		end else if (b >= CIDR_PROD_LO_LSB && b <= PROD_LO_MSB) begin : g_prod_lo
			assign id_word[b] = CIDR_PRODUCT_CODE[b - CIDR_PROD_LO_LSB]; // see RL5
		end else if (b >= CIDR_REV_LO_LSB && b <= REV_LO_MSB) begin : g_rev_lo
			assign id_word[b] = CIDR_REVISION_CODE[b - CIDR_REV_LO_LSB]; // see RL2
		end else begin : g_rsvd
			assign id_word[b] = 1'b0;
		end
	end

	// Upper product code lane
	always_comb begin
		unique case (rd_kind)
			RD_ID: begin
				prod_hi_nxt = id_word[PROD_HI_MSB:CIDR_PROD_HI_LSB]; // see RL5
			end
			RD_MISS: begin
				prod_hi_nxt = CIDR_UNMAPPED_READ[PROD_HI_MSB:CIDR_PROD_HI_LSB];
			end
			RD_NONE: begin
				prod_hi_nxt = CIDR_RDATA_RST[PROD_HI_MSB:CIDR_PROD_HI_LSB];
			end
			default: begin
				prod_hi_nxt = CIDR_RDATA_RST[PROD_HI_MSB:CIDR_PROD_HI_LSB];
			end
		endcase
	end

	// Held for one cycle, then back to idle zero
	always_ff @(posedge core_clk) begin
		if (srst) begin
			prod_hi_r <= CIDR_RDATA_RST[PROD_HI_MSB:CIDR_PROD_HI_LSB]; // see RL1
		end else begin
			prod_hi_r <= prod_hi_nxt;
		end
	end

	// Upper revision code lane
	always_comb begin
		unique case (rd_kind)
			RD_ID: begin
				rev_hi_nxt = id_word[REV_HI_MSB:CIDR_REV_HI_LSB]; // see RL2
			end
			RD_MISS: begin
				rev_hi_nxt = CIDR_UNMAPPED_READ[REV_HI_MSB:CIDR_REV_HI_LSB];
			end
			RD_NONE: begin
				rev_hi_nxt = CIDR_RDATA_RST[REV_HI_MSB:CIDR_REV_HI_LSB];
			end
			default: begin
				rev_hi_nxt = CIDR_RDATA_RST[REV_HI_MSB:CIDR_REV_HI_LSB];
			end
		endcase
	end

	// Writes never reach this flop, so the code cannot be altered
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rev_hi_r <= CIDR_RDATA_RST[REV_HI_MSB:CIDR_REV_HI_LSB]; // see RL1
		end else begin
			rev_hi_r <= rev_hi_nxt;
		end
	end

	// Reserved lane, zero on every path
	always_comb begin
		unique case (rd_kind)
			RD_ID: begin
				rsvd_nxt = id_word[RSVD_BIT];
			end
			RD_MISS: begin
				rsvd_nxt = CIDR_UNMAPPED_READ[RSVD_BIT];
			end
			RD_NONE: begin
				rsvd_nxt = CIDR_RDATA_RST[RSVD_BIT];
			end
			default: begin
				rsvd_nxt = CIDR_RDATA_RST[RSVD_BIT];
			end
		endcase
	end

	// Kept as a flop so every read bit has the same timing
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rsvd_r <= CIDR_RDATA_RST[RSVD_BIT]; // see RL1
		end else begin
			rsvd_r <= rsvd_nxt;
		end
	end

	// Strap status lane, fed from the latch and never the live pins
	always_comb begin
		unique case (rd_kind)
			RD_ID: begin
				strap_rd_nxt = id_word[STRAP_MSB:CIDR_STRAP_LSB]; // see RL3
			end
			RD_MISS: begin
				strap_rd_nxt = CIDR_UNMAPPED_READ[STRAP_MSB:CIDR_STRAP_LSB];
			end
			RD_NONE: begin
				strap_rd_nxt = CIDR_RDATA_RST[STRAP_MSB:CIDR_STRAP_LSB];
			end
			default: begin
				strap_rd_nxt = CIDR_RDATA_RST[STRAP_MSB:CIDR_STRAP_LSB];
			end
		endcase
	end

	// Read too early after release and the field reads only the tied-high bit 19
	always_ff @(posedge core_clk) begin
		if (srst) begin
			strap_rd_r <= CIDR_RDATA_RST[STRAP_MSB:CIDR_STRAP_LSB]; // see RL1
		end else begin
			strap_rd_r <= strap_rd_nxt;
		end
	end

	// Buffer size lane, in 4 KB units
	always_comb begin
		unique case (rd_kind)
			RD_ID: begin
				bufsz_nxt = id_word[BUFSZ_MSB:CIDR_BUFSZ_LSB]; // see RL5
			end
			RD_MISS: begin
				bufsz_nxt = CIDR_UNMAPPED_READ[BUFSZ_MSB:CIDR_BUFSZ_LSB];
			end
			RD_NONE: begin
				bufsz_nxt = CIDR_RDATA_RST[BUFSZ_MSB:CIDR_BUFSZ_LSB];
			end
			default: begin
				bufsz_nxt = CIDR_RDATA_RST[BUFSZ_MSB:CIDR_BUFSZ_LSB];
			end
		endcase
	end

	// Held for one cycle, then back to idle zero
	always_ff @(posedge core_clk) begin
		if (srst) begin
			bufsz_r <= CIDR_RDATA_RST[BUFSZ_MSB:CIDR_BUFSZ_LSB]; // see RL1
		end else begin
			bufsz_r <= bufsz_nxt;
		end
	end

	// Lower product code lane, same code as the upper copy
	always_comb begin
		unique case (rd_kind)
			RD_ID: begin
				prod_lo_nxt = id_word[PROD_LO_MSB:CIDR_PROD_LO_LSB]; // see RL5
			end
			RD_MISS: begin
				prod_lo_nxt = CIDR_UNMAPPED_READ[PROD_LO_MSB:CIDR_PROD_LO_LSB];
			end
			RD_NONE: begin
				prod_lo_nxt = CIDR_RDATA_RST[PROD_LO_MSB:CIDR_PROD_LO_LSB];
			end
			default: begin
				prod_lo_nxt = CIDR_RDATA_RST[PROD_LO_MSB:CIDR_PROD_LO_LSB];
			end
		endcase
	end

	// Held for one cycle, then back to idle zero
	always_ff @(posedge core_clk) begin
		if (srst) begin
			prod_lo_r <= CIDR_RDATA_RST[PROD_LO_MSB:CIDR_PROD_LO_LSB]; // see RL1
		end else begin
			prod_lo_r <= prod_lo_nxt;
		end
	end

	// Lower revision code lane, lets a narrow reader see the code
	always_comb begin
		unique case (rd_kind)
			RD_ID: begin
				rev_lo_nxt = id_word[REV_LO_MSB:CIDR_REV_LO_LSB]; // see RL2
			end
			RD_MISS: begin
				rev_lo_nxt = CIDR_UNMAPPED_READ[REV_LO_MSB:CIDR_REV_LO_LSB];
			end
			RD_NONE: begin
				rev_lo_nxt = CIDR_RDATA_RST[REV_LO_MSB:CIDR_REV_LO_LSB];
			end
			default: begin
				rev_lo_nxt = CIDR_RDATA_RST[REV_LO_MSB:CIDR_REV_LO_LSB];
			end
		endcase
	end

	// Held for one cycle, then back to idle zero
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rev_lo_r <= CIDR_RDATA_RST[REV_LO_MSB:CIDR_REV_LO_LSB]; // see RL1
		end else begin
			rev_lo_r <= rev_lo_nxt;
		end
	end

	// Lanes side by side make the read word; every bit comes from a flop
	always_comb begin
		rdata                               = CIDR_RDATA_RST;
		rdata[PROD_HI_MSB:CIDR_PROD_HI_LSB] = prod_hi_r;
		rdata[REV_HI_MSB:CIDR_REV_HI_LSB]   = rev_hi_r;
		rdata[RSVD_BIT]                     = rsvd_r;
		rdata[STRAP_MSB:CIDR_STRAP_LSB]     = strap_rd_r;
		rdata[BUFSZ_MSB:CIDR_BUFSZ_LSB]     = bufsz_r;
		rdata[PROD_LO_MSB:CIDR_PROD_LO_LSB] = prod_lo_r;
		rdata[REV_LO_MSB:CIDR_REV_LO_LSB]   = rev_lo_r;
	end

	// Write port kept for bus symmetry; writes are dropped without effect
	assign unused_w = wr_stb ^ (^wdata); // see RL2

endmodule // cidr_top

/* File: cidr_top_assertions.sv */
module cidr_chk
	import cidr_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic [6:0]  config_strap_pins,
	input wire logic [7:0]  addr,
	input wire logic        rd_stb,
	input wire logic [31:0] rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [6:0] cap_r;
	logic       was_rst_r;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// Own copy of the straps, so a late capture edge shows up
	always_ff @(posedge core_clk) begin
		was_rst_r <= srst;
		if (was_rst_r && !srst) cap_r <= config_strap_pins;
	end
	a_idle_zero: assert property (!rd_stb |=> rdata == 32'h0) else $error("idle");
	a_rev_pair: assert property (rd_stb && addr == 8'h00 |=> rdata[25:24] == CIDR_REVISION_CODE
		&& rdata[1:0] == CIDR_REVISION_CODE) else $error("rev");
	a_tied_one: assert property (rd_stb && addr == 8'h00 |=> rdata[19]) else $error("tied");
	a_strap_hold: assert property (rd_stb && addr == 8'h00 && !was_rst_r
		|=> rdata[22:16] == (cap_r | 7'h08)) else $error("strap");
	a_prod_size: assert property (rd_stb && addr == 8'h00 |=> rdata[31:26] == CIDR_PRODUCT_CODE
		&& rdata[7:2] == CIDR_PRODUCT_CODE && rdata[15:8] == 8'h28) else $error("prod");
endmodule // cidr_chk
bind cidr_top cidr_chk cidr_chk_i (.core_clk, .srst, .config_strap_pins, .addr, .rd_stb, .rdata);

/* File: cidr_top_tb_top.sv */
module cidr_top_tb_top
	import cidr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        core_clk, srst, wr_stb, rd_stb;
	logic [6:0]  config_strap_pins;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	int          miscompares, comparisons;
	cidr_top cidr_top_i (.core_clk, .srst, .config_strap_pins, .addr, .wdata, .wr_stb, .rd_stb, .rdata);
	always #12.5 core_clk = ~core_clk;
	function automatic logic [31:0] id(input logic [6:0] s);
		return {CIDR_PRODUCT_CODE, CIDR_REVISION_CODE, 1'b0, s | 7'h08, 8'h28,
			CIDR_PRODUCT_CODE, CIDR_REVISION_CODE};
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %0t rdata %h exp %h", $time, s, e);
		end
	endtask
	task automatic close_out;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge core_clk) rd_stb <= 1'b0;
		#1 chk(rdata, e);
		@(posedge core_clk);
	endtask
	// Straps move right after capture to prove they are held
	task automatic rst(input logic [6:0] s);
		srst <= 1'b1;
		config_strap_pins <= s;
		repeat (6) @(posedge core_clk);
		chk(rdata, 32'h0);
		srst <= 1'b0;
		@(posedge core_clk) config_strap_pins <= ~s;
	endtask
	initial begin
		{core_clk, srst, config_strap_pins, addr, wdata, wr_stb, rd_stb} = '0;
		rst(7'h55);
		rd(8'h00, id(7'h55));
		addr <= 8'h00;
		wdata <= 32'hFFFF_FFFF;
		wr_stb <= 1'b1;
		@(posedge core_clk) wr_stb <= 1'b0;
		rd(8'h00, id(7'h55));
		rd(8'h04, 32'h0);
		rd(8'h00, id(7'h55));
		rst(7'h22);
		rd(8'h00, id(7'h22));
		close_out;
	end
	// Run needs about 25 cycles
	initial begin
		#20000 miscompares++;
		close_out;
	end
endmodule // cidr_top_tb_top
